// >>> hdl/nfc_ctrl.sv
/*
 * nand flash controller: software posts one bus cycle at a time (command,
 * address, data in, data out, deselect) through avalon-mm registers and the
 * controller drives the strobes and the shared port of the flash.
 * assumes a single 250 MHz clock and flash pins synchronous to it.
 */
// Summary of operation
// - five address cycles, unused bits low
// - cycle kind decoded from strobe levels
// - during read busy keep strobes high; code blocks only commands other than 70/71/ff, not address or data cycles
// - page read is 00, address, 30
// - read column change is 05, two cycles, e0
// - cache read 31 continue, 3f last
// - program 80, closes with 10 or 15
// - 85 plus two cycles moves input column
// - page copy 00-3a, then 8c-15 or 8c-10
// - after 15 ending, poll status then ff
`timescale 1ns/1ps
`include "nfc_consts.svh"
module nfc_ctrl
    import nfc_pkg::*;
(
    input  wire logic        clk,                  // system clock
    input  wire logic        rst_n,                // async reset, active low
    input  wire logic [3:0]  avs_address,          // byte address
    input  wire logic        avs_read,             // read request
    input  wire logic        avs_write,            // write request
    input  wire logic [31:0] avs_writedata,        // write data
    output logic [31:0]      avs_readdata,         // read data
    output logic             avs_waitrequest,      // stall
    output logic             command_latch_strobe, // flash command latch
    output logic             address_latch_strobe, // flash address latch
    output logic             device_select_n,      // flash select
    output logic             write_strobe_n,       // flash write strobe
    output logic             read_strobe_n,        // flash read strobe
    output logic             program_guard_n,      // flash write guard
    input  wire logic [7:0]  shared_port_in,       // port level seen
    output logic [7:0]       shared_port_out,      // port drive value
    output logic             shared_port_oe,       // port driven
    input  wire logic        ready_busy_n          // flash ready, low busy
);
    localparam int TW = 5;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    nfc_state_t  state, next_state;
    nfc_cyc_t    kind, next_kind;
    logic [7:0]  obyte, next_obyte;
    logic [7:0]  rbyte, next_rbyte;
    logic        guard, next_guard;
    logic        sel_n, next_sel_n;
    logic        refused, next_refused;
    logic [2:0]  acount, next_acount;
    logic [11:0] column, next_column;
    logic        tload;
    logic [TW-1:0] tcycles;
    logic        expire;
    logic        post;

    if (`NFC_WHR_CYC >= (1 << TW)) begin : g_timer_check
        $error("nfc_ctrl: timer too narrow");
    end

    function automatic logic is_busy_ok(input logic [7:0] c);
        // status poll and reset pass while busy
        is_busy_ok = (c == `NFC_CMD_STATUS) || (c == `NFC_CMD_STATUS_M) ||
                     (c == `NFC_CMD_RESET);
    endfunction

    function automatic logic is_prog_erase(input logic [7:0] c);
        is_prog_erase = (c == `NFC_CMD_PROG2) || (c == `NFC_CMD_PROG_CACHE) ||
                        (c == `NFC_CMD_PROG_DIST) || (c == `NFC_CMD_ERASE2);
    endfunction

    nfc_pulse_timer #(.W(TW)) u_timer (
        .clk    (clk),
        .rst_n  (rst_n),
        .load   (tload),
        .cycles (tcycles),
        .expire (expire)
    );

    // software posts each sequence cycle by cycle
    assign post = avs_write && (avs_address == `NFC_REG_CTRL) && (state == NFC_ST_IDLE);

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always_comb begin
        next_state   = state;
        next_kind    = kind;
        next_obyte   = obyte;
        next_rbyte   = rbyte;
        next_guard   = guard;
        next_sel_n   = sel_n;
        next_refused = refused;
        next_acount  = acount;
        next_column  = column;
        tload        = 1'b0;
        tcycles      = TW'(`NFC_PULSE_CYC);
        case (state)
            NFC_ST_IDLE: begin
                if (post) begin
                    next_kind  = nfc_cyc_t'(avs_writedata[`NFC_CTRL_KIND_LSB +: 3]);
                    next_obyte = avs_writedata[7:0];
                    next_guard = avs_writedata[`NFC_CTRL_GUARD_BIT];
                    if (next_kind == NFC_CYC_CMD && !ready_busy_n &&
                        !is_busy_ok(avs_writedata[7:0])) begin
                        next_refused = 1'b1;
                    end else if (next_kind == NFC_CYC_CMD &&
                                 !avs_writedata[`NFC_CTRL_GUARD_BIT] &&
                                 is_prog_erase(avs_writedata[7:0])) begin
                        next_refused = 1'b1;
                    end else begin
                        next_refused = 1'b0;
                        next_state   = NFC_ST_SETUP;
                        next_sel_n   = (next_kind == NFC_CYC_DESEL);
                        tload        = 1'b1;
                    end
                end
            end
            NFC_ST_SETUP: begin
                if (expire) begin
                    next_state = (kind == NFC_CYC_DESEL) ? NFC_ST_DONE : NFC_ST_PULSE;
                    tload      = 1'b1;
                end
            end
            NFC_ST_PULSE: begin
                if (expire) begin
                    next_state = NFC_ST_HOLD;
                    tload      = 1'b1;
                    tcycles    = TW'(`NFC_WHR_CYC);
                    // byte taken at end of read pulse, column advances
                    if (kind == NFC_CYC_DOUT) begin
                        next_rbyte  = shared_port_in;
                        next_column = column + 12'h001;
                    end
                    if (kind == NFC_CYC_ADDR) begin
                        next_acount = (acount == `NFC_ADDR_LAST) ? 3'h0 : acount + 3'h1;
                    end
                    if (kind == NFC_CYC_CMD) begin
                        next_acount = 3'h0;
                    end
                end
            end
            NFC_ST_HOLD: begin
                if (expire) begin
                    next_state = NFC_ST_DONE;
                end
            end
            NFC_ST_DONE: begin
                next_state = NFC_ST_IDLE;
            end
            default: begin
                next_state = NFC_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state   <= NFC_ST_IDLE;
            kind    <= NFC_CYC_DESEL;
            obyte   <= 8'h00;
            rbyte   <= 8'h00;
            guard   <= 1'b0;
            sel_n   <= 1'b1;
            refused <= 1'b0;
            acount  <= 3'h0;
            column  <= 12'h000;
        end else begin
            state   <= next_state;
            kind    <= next_kind;
            obyte   <= next_obyte;
            rbyte   <= next_rbyte;
            guard   <= next_guard;
            sel_n   <= next_sel_n;
            refused <= next_refused;
            acount  <= next_acount;
            column  <= next_column;
        end
    end

    // ------------------------------------------------------------
    // pin drive
    // ------------------------------------------------------------
    logic in_cycle;
    logic pulse;
    assign in_cycle = (state == NFC_ST_SETUP) || (state == NFC_ST_PULSE) ||
                      (state == NFC_ST_HOLD);
    assign pulse    = (state == NFC_ST_PULSE);

    // strobe levels per cycle kind; latch on write rise
    // outside a cycle both strobes rest high
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            command_latch_strobe <= 1'b0;
            address_latch_strobe <= 1'b0;
            device_select_n      <= 1'b1;
            write_strobe_n       <= 1'b1;
            read_strobe_n        <= 1'b1;
            program_guard_n      <= 1'b0;
            shared_port_out      <= 8'h00;
            shared_port_oe       <= 1'b0;
        end else begin
            command_latch_strobe <= (next_state != NFC_ST_IDLE) && (next_kind == NFC_CYC_CMD);
            address_latch_strobe <= (next_state != NFC_ST_IDLE) && (next_kind == NFC_CYC_ADDR);
            // select released only by a deselect cycle
            device_select_n      <= next_sel_n;
            write_strobe_n       <= !((next_state == NFC_ST_PULSE) &&
                                      (next_kind != NFC_CYC_DOUT));
            // flash drives port only during this low phase
            read_strobe_n        <= !((next_state == NFC_ST_PULSE) &&
                                      (next_kind == NFC_CYC_DOUT));
            program_guard_n      <= next_guard;
            shared_port_out      <= next_obyte;
            shared_port_oe       <= (next_state == NFC_ST_SETUP || next_state == NFC_ST_PULSE ||
                                     next_state == NFC_ST_HOLD) &&
                                    (next_kind == NFC_CYC_CMD || next_kind == NFC_CYC_ADDR ||
                                     next_kind == NFC_CYC_DIN);
        end
    end

    // ------------------------------------------------------------
    // avalon-mm slave
    // ------------------------------------------------------------
    // ctrl writes stall until the sequencer is idle; reads take one wait
    // state so that read data come straight from a register
    logic        rd_valid;
    logic        next_rd_valid;
    logic [31:0] next_readdata;

    assign avs_waitrequest = (avs_write && (avs_address == `NFC_REG_CTRL) &&
                              (state != NFC_ST_IDLE)) || (avs_read && !rd_valid);

    always_comb begin
        next_rd_valid = avs_read && !rd_valid;
        next_readdata = 32'h0000_0000;
        case (avs_address)
            `NFC_REG_DATA: next_readdata = {24'h000000, rbyte};
            `NFC_REG_STATUS: begin
                next_readdata[`NFC_ST_BUSY_BIT]        = in_cycle || pulse;
                next_readdata[`NFC_ST_READY_BIT]       = ready_busy_n;
                next_readdata[`NFC_ST_REFUSED_BIT]     = refused;
                next_readdata[`NFC_ST_ACOUNT_LSB +: 3] = acount;
            end
            `NFC_REG_COLUMN: next_readdata = {20'h00000, column};
            default: next_readdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_valid     <= 1'b0;
            avs_readdata <= 32'h0000_0000;
        end else begin
            rd_valid     <= next_rd_valid;
            avs_readdata <= next_readdata;
        end
    end
endmodule

// >>> inc/nfc_consts.svh
/*
 * constants for the nand flash controller: command codes, address layout,
 * geometry, strobe timing counts and register map of the software port.
 * assumes a 250 MHz system clock.
 */
`ifndef NFC_CONSTS_SVH
`define NFC_CONSTS_SVH

// ------------------------------------------------------------
// command codes
// ------------------------------------------------------------
`define NFC_CMD_READ1       8'h00
`define NFC_CMD_READ2       8'h30
`define NFC_CMD_COLRD1      8'h05
`define NFC_CMD_COLRD2      8'he0
`define NFC_CMD_CACHE_NEXT  8'h31
`define NFC_CMD_CACHE_LAST  8'h3f
`define NFC_CMD_PROG1       8'h80
`define NFC_CMD_PROG2       8'h10
`define NFC_CMD_PROG_CACHE  8'h15
`define NFC_CMD_PROG_DIST   8'h11
`define NFC_CMD_PROG_PAIR   8'h81
`define NFC_CMD_COLWR       8'h85
`define NFC_CMD_COPY_RD     8'h3a
`define NFC_CMD_COPY_WR     8'h8c
`define NFC_CMD_ERASE1      8'h60
`define NFC_CMD_ERASE2      8'hd0
`define NFC_CMD_ID          8'h90
`define NFC_CMD_STATUS      8'h70
`define NFC_CMD_STATUS_M    8'h71
`define NFC_CMD_RESET       8'hff

// ------------------------------------------------------------
// address layout and geometry
// ------------------------------------------------------------
`define NFC_COL_W           12
`define NFC_ROW_W           17
`define NFC_PAGE_LSB        0
`define NFC_PAGE_W          6
`define NFC_BLOCK_LSB       6
`define NFC_BLOCK_W         11
`define NFC_PAGE_BYTES      12'd2176
`define NFC_MAIN_BYTES      12'd2048
`define NFC_SPARE_BYTES     12'd128
`define NFC_PAGES_PER_BLOCK 7'd64
// count value of the fifth, last address cycle of a full address
`define NFC_ADDR_LAST       3'h4

// ------------------------------------------------------------
// timing: pulse, setup and hold length in ns, rounded up to cycles
// ------------------------------------------------------------
`define NFC_CLK_NS          4
`define NFC_PULSE_NS        12
`define NFC_WHR_NS          60
`define NFC_PULSE_CYC       ((`NFC_PULSE_NS + `NFC_CLK_NS - 1) / `NFC_CLK_NS)
`define NFC_WHR_CYC         ((`NFC_WHR_NS + `NFC_CLK_NS - 1) / `NFC_CLK_NS)

// ------------------------------------------------------------
// register map (byte addresses on the word-wide bus)
// ------------------------------------------------------------
`define NFC_REG_CTRL        4'h0
`define NFC_REG_DATA        4'h4
`define NFC_REG_STATUS      4'h8
`define NFC_REG_COLUMN      4'hc
// ctrl write: [7:0] byte, [10:8] cycle kind, bit 11 guard level
`define NFC_CTRL_KIND_LSB   8
`define NFC_CTRL_GUARD_BIT  11
// status read fields
`define NFC_ST_BUSY_BIT     0
`define NFC_ST_READY_BIT    1
`define NFC_ST_REFUSED_BIT  2
`define NFC_ST_ACOUNT_LSB   4

`endif

// >>> inc/nfc_pkg.sv
/*
 * types shared by the nand flash controller files.
 * assumes nfc_consts.svh is on the include path.
 */
package nfc_pkg;

    typedef enum logic [2:0] {
        NFC_CYC_CMD,
        NFC_CYC_ADDR,
        NFC_CYC_DIN,
        NFC_CYC_DOUT,
        NFC_CYC_DESEL
    } nfc_cyc_t;

    typedef enum logic [2:0] {
        NFC_ST_IDLE,
        NFC_ST_SETUP,
        NFC_ST_PULSE,
        NFC_ST_HOLD,
        NFC_ST_DONE
    } nfc_state_t;

endpackage

// >>> hdl/nfc_pulse_timer.sv
/*
 * down counter giving a one-cycle enable when a strobe phase has lasted
 * its programmed number of cycles.
 * assumes load and the count come from the controller sequencer.
 */
`timescale 1ns/1ps
module nfc_pulse_timer
    import nfc_pkg::*;
#(
    parameter int W = 5
) (
    input  wire logic         clk,      // system clock
    input  wire logic         rst_n,    // async reset, active low
    input  wire logic         load,     // start a new phase
    input  wire logic [W-1:0] cycles,   // phase length in cycles
    output logic              expire    // one-cycle end of phase
);
    logic [W-1:0] count;
    logic [W-1:0] next_count;
    logic         next_expire;

    if (W < 2) begin : g_width_check
        $error("nfc_pulse_timer: W too small");
    end

    always_comb begin
        next_count  = count;
        next_expire = 1'b0;
        if (load) begin
            next_count  = cycles;
            // a one-cycle phase ends at the very next edge
            next_expire = (cycles == W'(1));
        end else if (count != '0) begin
            next_count  = count - W'(1);
            // flag one edge early: the sequencer only sees it registered
            next_expire = (count == W'(2));
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count  <= '0;
            expire <= 1'b0;
        end else begin
            count  <= next_count;
            expire <= next_expire;
        end
    end
endmodule

// >>> tb/nfc_flash_model.sv
/* flash device model: latches commands and addresses, serves read bytes
   and times busy periods. assumes its pins are synchronous to clk. */
`timescale 1ns/1ps
module nfc_flash_model (
    input  wire logic       clk,                  // sample clock
    input  wire logic       rst_n,                // reset, active low
    input  wire logic       command_latch_strobe, // command latch
    input  wire logic       address_latch_strobe, // address latch
    input  wire logic       device_select_n,      // select
    input  wire logic       write_strobe_n,       // write strobe
    input  wire logic       read_strobe_n,        // read strobe
    input  wire logic       program_guard_n,      // guard
    input  wire logic [7:0] shared_port_in,       // port level
    output logic      [7:0] m_out,                // port drive value
    output logic            m_oe,                 // port driven
    output logic            ready_busy_n          // ready, low busy
);
    logic        wr_q, rd_q, standby;
    logic [2:0]  acnt;
    logic [11:0] col;
    logic [16:0] row;
    logic [7:0]  b;
    int          busy, n_prog, n_erase;
    assign b = shared_port_in;
    assign ready_busy_n = (busy == 0);
    // drive only while selected and reading
    assign m_oe = !device_select_n && write_strobe_n && !read_strobe_n;
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            {wr_q, rd_q} <= 2'b11;
            {standby, acnt, col, row, m_out, busy, n_prog, n_erase} <= '0;
        end else begin
            wr_q <= write_strobe_n;
            rd_q <= read_strobe_n;
            if (busy != 0)
                busy <= busy - 1;
            standby <= device_select_n && ready_busy_n;
            if (write_strobe_n && !wr_q && !device_select_n) begin
                // only status and reset taken while busy
                if (command_latch_strobe && (ready_busy_n || b inside {8'h70, 8'h71, 8'hff})) begin
                    acnt <= (b == 8'h60) ? 3'd2 : 3'd0;
                    // read starts without a prior 00
                    if (b == 8'h30)
                        busy <= 60;
                    if (b inside {8'h10, 8'h15, 8'hd0} && program_guard_n) begin
                        busy <= 60;
                        n_prog <= n_prog + int'(b != 8'hd0);
                        n_erase <= n_erase + int'(b == 8'hd0);
                    end
                end
                if (address_latch_strobe) begin
                    acnt <= acnt + 3'd1;
                    case (acnt)
                        3'd0: col[7:0] <= b;
                        3'd1: col[11:8] <= b[3:0];
                        3'd2: row[7:0] <= b;
                        3'd3: row[15:8] <= b;
                        default: row[16] <= b[0];
                    endcase
                end
            end
            // one byte per read strobe fall, column advances
            // 12-bit column spans main and spare bytes
            if (!read_strobe_n && rd_q && !device_select_n) begin
                m_out <= col[7:0] ^ row[7:0];
                col <= col + 12'd1;
            end
        end
    end
endmodule

// >>> tb/nfc_ctrl_checker.sv
/* assertions on the flash pins of nfc_ctrl.
   assumes it is bound into nfc_ctrl, one clock domain. */
`timescale 1ns/1ps
module nfc_ctrl_checker (
    input wire logic       clk,                  // clock
    input wire logic       rst_n,                // reset, active low
    input wire logic       command_latch_strobe, // command latch
    input wire logic       address_latch_strobe, // address latch
    input wire logic       device_select_n,      // select
    input wire logic       write_strobe_n,       // write strobe
    input wire logic       read_strobe_n,        // read strobe
    input wire logic       program_guard_n,      // guard
    input wire logic [7:0] shared_port_out,      // port drive value
    input wire logic       shared_port_oe,       // port driven
    input wire logic       ready_busy_n          // flash ready
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    latch_excl_a: assert property (!(command_latch_strobe && address_latch_strobe))
        else $error("latch overlap");
    strobe_excl_a: assert property (write_strobe_n || read_strobe_n)
        else $error("strobe overlap");
    latch_select_a: assert property (command_latch_strobe |-> !device_select_n)
        else $error("latch unselected");
    cmd_latch_a: assert property ($rose(write_strobe_n) && command_latch_strobe |->
        !device_select_n && read_strobe_n && $past(shared_port_oe))
        else $error("bad command latch");
    addr_latch_a: assert property ($rose(write_strobe_n) && address_latch_strobe |->
        !command_latch_strobe && !device_select_n && $past(shared_port_oe))
        else $error("bad address latch");
    wr_pulse_a: assert property ($fell(write_strobe_n) |->
        (!write_strobe_n)[*3] ##1 write_strobe_n)
        else $error("write pulse length");
    rd_pulse_a: assert property ($fell(read_strobe_n) |->
        (!read_strobe_n && !shared_port_oe)[*3] ##1 read_strobe_n)
        else $error("read pulse or port clash");
    guard_a: assert property ($fell(write_strobe_n) && command_latch_strobe &&
        shared_port_out inside {8'h10, 8'h15, 8'h11, 8'hd0} |-> program_guard_n)
        else $error("start under guard");
    busy_cmd_a: assert property ($fell(write_strobe_n) && !ready_busy_n |->
        command_latch_strobe && shared_port_out inside {8'h70, 8'h71, 8'hff})
        else $error("cycle sent while busy");
    cover property ($rose(write_strobe_n) && command_latch_strobe);
    cover property ($rose(write_strobe_n) && address_latch_strobe);
    cover property ($fell(read_strobe_n));
endmodule
bind nfc_ctrl nfc_ctrl_checker u_chk (.*);

// >>> tb/nand_command_address_interface_bench.sv
/* bench for nfc_ctrl: avalon-mm master tasks post one flash bus cycle at a
   time against a flash model. assumes design and package compiled first. */
`timescale 1ns/1ps
module nand_command_address_interface_bench;
    logic        clk, rst_n, avs_read, avs_write, grd;
    logic [3:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata, q;
    logic        avs_waitrequest, command_latch_strobe, address_latch_strobe;
    logic        device_select_n, write_strobe_n, read_strobe_n, program_guard_n;
    logic [7:0]  shared_port_out, port_lvl, m_out;
    logic        shared_port_oe, ready_busy_n, m_oe;
    int          n_errors = 0;
    int          compares = 0;
    int          cyc = 0;
    // undriven port shows a changing pattern, never a held value
    assign port_lvl = shared_port_oe ? shared_port_out : (m_oe ? m_out : cyc[7:0]);
    nfc_ctrl u_dut (.*, .shared_port_in(port_lvl));
    nfc_flash_model u_flash (.*, .shared_port_in(port_lvl));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            n_errors = n_errors + 1;
            end_of_test();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares = compares + 1;
        if (got !== exp) begin
            n_errors = n_errors + 1;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    // request held until a rising edge with waitrequest low; one idle
    // edge before each request so no strobe is assigned twice at once
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= d;
        @(posedge clk);
        while (avs_waitrequest !== 1'b0) @(posedge clk);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task automatic put(input logic [2:0] k, input logic [7:0] b);
        bus(1'b1, 4'h0, {20'h0, grd, k, b});
    endtask
    task automatic idle;
        do bus(1'b0, 4'h8, 32'h0); while (q[0] !== 1'b0);
    endtask
    task automatic rdy;
        while (ready_busy_n !== 1'b1) @(posedge clk);
    endtask
    task automatic rd_byte(input logic [7:0] exp);
        put(3'd3, 8'h00);
        idle();
        bus(1'b0, 4'h4, 32'h0);
        chk(q[7:0], exp);
    endtask
    task automatic t_read;
        logic [7:0] ab [5] = '{8'h23, 8'h01, 8'h45, 8'h00, 8'h01};
        foreach (ab[i]) put(3'd1, ab[i]);
        put(3'd0, 8'h30);
        idle();
        chk(ready_busy_n, 1'b0);
        rdy();
        rd_byte(8'h23 ^ 8'h45);
        rd_byte(8'h24 ^ 8'h45);
        put(3'd0, 8'h05);
        put(3'd1, 8'h10);
        put(3'd1, 8'h07);
        put(3'd0, 8'he0);
        rd_byte(8'h10 ^ 8'h45);
        bus(1'b0, 4'hc, 32'h0);
        chk(q, 32'h3);
    endtask
    task automatic t_busy;
        put(3'd0, 8'h30);
        idle();
        put(3'd0, 8'h80);
        bus(1'b0, 4'h8, 32'h0);
        chk(q[2], 1'b1);
        put(3'd0, 8'h70);
        bus(1'b0, 4'h8, 32'h0);
        chk(q[2], 1'b0);
        rdy();
    endtask
    task automatic t_prog;
        logic [7:0] cl [3] = '{8'h10, 8'h15, 8'hd0};
        int n0;
        for (int i = 0; i < 3; i++) begin
            n0 = u_flash.n_prog;
            for (int g = 0; g < 2; g++) begin
                grd = g[0];
                put(3'd0, 8'h80);
                repeat (5) put(3'd1, 8'h02);
                put(3'd2, 8'haa);
                put(3'd0, cl[i]);
                idle();
                chk(q[2], !grd);
                rdy();
                put(3'd0, 8'hff);
            end
            chk(u_flash.n_prog, n0 + int'(i < 2));
        end
    endtask
    task automatic t_erase;
        int n0;
        n0 = u_flash.n_erase;
        put(3'd0, 8'h60);
        repeat (3) put(3'd1, 8'h40);
        idle();
        chk(q[6:4], 3'd3);
        put(3'd0, 8'hd0);
        idle();
        chk(ready_busy_n, 1'b0);
        rdy();
        chk(u_flash.n_erase, n0 + 1);
    endtask
    task automatic t_standby;
        put(3'd4, 8'h00);
        idle();
        chk(device_select_n, 1'b1);
        chk(u_flash.standby, 1'b1);
        put(3'd0, 8'h30);
        put(3'd4, 8'h00);
        idle();
        chk(u_flash.standby, 1'b0);
        rdy();
    endtask
    task automatic end_of_test;
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        {avs_read, avs_write, grd} = 3'b001;
        avs_address = 4'h0;
        avs_writedata = 32'h0;
        rst_n = 1'b0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        t_read();
        t_busy();
        t_prog();
        t_erase();
        t_standby();
        end_of_test();
    end
endmodule
